// [pkg/buck_ctl_pkg.sv]
// Shared constants, register map and state types of the converter control logic.
// Assumes a 20 MHz system clock; all times are converted to cycles here.
package buck_ctl_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 20;
  localparam int BOOT_DIS_US = 100;
  localparam int BOOT_DIS_CYC = BOOT_DIS_US * CLK_MHZ;
  localparam int SHORT_OFF_US = 2000;
  localparam int SHORT_OFF_CYC = SHORT_OFF_US * CLK_MHZ;
  localparam int PFM_ON_CYC = 4;
  localparam int PEAK_LIMIT = 16;
  localparam int TMR_W = 16;

  // Register byte offsets
  localparam logic [4:0] OFS_COMMAND = 5'h00;
  localparam logic [4:0] OFS_LEVEL0 = 5'h04;
  localparam logic [4:0] OFS_LEVEL1 = 5'h08;
  localparam logic [4:0] OFS_LIMIT = 5'h0C;
  localparam logic [4:0] OFS_GOOD = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // Command register fields
  localparam int CMD_PWM0_BIT = 7;
  localparam int CMD_PWM1_BIT = 6;
  localparam int CMD_GATE_BIT = 5;
  localparam int CMD_SLEEP_BIT = 4;
  localparam int CMD_ON0_BIT = 3;
  localparam int CMD_ON1_BIT = 2;

  // Limit configuration fields
  localparam int LIM_PEAK_LSB = 0;
  localparam int LIM_PREW_LSB = 2;
  localparam int LIM_AUTO_RESTART_BIT_BIT = 4;

  // Good indicator register field
  localparam int GOOD_DIS_BIT = 0;

  // Status register fields
  localparam int STA_SHORT_BIT = 0;
  localparam int STA_WARN_BIT = 1;
  localparam int STA_PREW_BIT = 2;
  localparam int STA_HOT_BIT = 3;
  localparam int STA_PFM_BIT = 4;
  localparam int STA_ON_BIT = 5;
  localparam int STA_LOCK_BIT = 6;

  // Reset values
  localparam logic [7:0] RST_COMMAND = 8'h2C;
  localparam logic [7:0] RST_LEVEL = 8'h48;
  localparam logic [4:0] RST_LIMIT = 5'h03;
  localparam logic [0:0] RST_GOOD = 1'h1;

  // Synchronised pin indices
  localparam int PIN_EN = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_PULLUP = 2;
  localparam int PIN_LOWSUP = 3;
  localparam int PIN_HOT = 4;
  localparam int PIN_WARN = 5;
  localparam int PIN_PREW = 6;
  localparam int PIN_DEMAND = 7;
  localparam int PIN_PEAK = 8;
  localparam int PIN_ZERO = 9;
  localparam int NPIN = 10;

  typedef enum {ST_OFF, ST_RUN, ST_SHORT_WAIT, ST_HOT_WAIT, ST_LOCKED} run_state_t;
  typedef enum {SW_IDLE, SW_HIGH, SW_LOW} sw_phase_t;

endpackage

// [pkg/off_timer_if.sv]
// Handshake between the control logic and its off-period timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface off_timer_if;
  import buck_ctl_pkg::*;
  logic clr;
  logic start;
  logic [TMR_W-1:0] load;
  logic done;
  modport ctl (output clr, output start, output load, input done);
  modport tmr (input clr, input start, input load, output done);
endinterface

// [verilog/off_timer.sv]
// One-shot down counter timing the forced off period after a short circuit.
// Assumes start is a one-cycle pulse; done is a one-cycle pulse from a flop.
`timescale 1ns/1ns
module off_timer (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  off_timer_if.tmr tmr
);
  import buck_ctl_pkg::*;

  logic [TMR_W-1:0] count;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count <= '0;
      tmr.done <= 1'b0;
    end
    else if (i_ce)
    begin
      tmr.done <= 1'b0;
      if (tmr.clr)
        count <= '0;
      else if (tmr.start)
        count <= tmr.load;
      else if (count != '0)
      begin
        count <= count - 1'b1;
        tmr.done <= (count == {{(TMR_W-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule

// [verilog/buck_converter_control_logic.sv]
// Digital control of a step-down converter: mode choice, switch drive, peak
// limit counting, short and thermal shutdown, enable and sleep logic.
// Assumes analog comparators and pins arrive asynchronously; Avalon-MM slave.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns

module buck_converter_control_logic #(
  parameter int SHORT_OFF_CYCLES = buck_ctl_pkg::SHORT_OFF_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_EN_PIN,
  input wire logic I_SET_SELECT_PIN,
  input wire logic I_PULLUP_DET,
  input wire logic I_LOW_SUPPLY_LOCKOUT,
  input wire logic I_OVERHEAT_SHUTDOWN,
  input wire logic I_WARN_HOT,
  input wire logic I_PREWARN_HOT,
  input wire logic I_HS_DEMAND,
  input wire logic I_PEAK_CMP,
  input wire logic I_ZERO_CMP,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic O_HS_ON,
  output logic O_LS_ON,
  output logic O_PULSE_SKIP_MODE,
  output logic O_CONV_ON,
  output logic O_SEQ_START,
  output logic O_SLEEP,
  output logic O_OFF_MODE,
  output logic O_DISCHARGE,
  output logic [7:0] O_TARGET_LEVEL,
  output logic [1:0] O_PEAK_CODE,
  output logic [1:0] O_PREWARN_CODE,
  output logic O_SHORT_CIRCUIT_EVENT
);
  import buck_ctl_pkg::*;

  if (SHORT_OFF_CYCLES < 1 || SHORT_OFF_CYCLES > 65535)
  begin : g_chk
    $error("SHORT_OFF_CYCLES must fit the 16-bit off timer");
  end

  // Two-flop synchronisers for every asynchronous input
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {I_ZERO_CMP, I_PEAK_CMP, I_HS_DEMAND, I_PREWARN_HOT, I_WARN_HOT,
                    I_OVERHEAT_SHUTDOWN, I_LOW_SUPPLY_LOCKOUT, I_PULLUP_DET,
                    I_SET_SELECT_PIN, I_EN_PIN};
  genvar g;
  for (g = 0; g < NPIN; g++)
  begin : g_sync
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
      if (!I_RSTN)
      begin
        pin_meta[g] <= 1'b0;
        pin_s[g] <= 1'b0;
      end
      else if (I_CE)
      begin
        pin_meta[g] <= pin_raw[g];
        pin_s[g] <= pin_meta[g];
      end
    end
  end

  logic en_s, sel_s, low_s, hot_s, dem_s, peak_s, zero_s;
  assign en_s = pin_s[PIN_EN];
  assign sel_s = pin_s[PIN_SEL];
  assign low_s = pin_s[PIN_LOWSUP];
  assign hot_s = pin_s[PIN_HOT];
  assign dem_s = pin_s[PIN_DEMAND];
  assign peak_s = pin_s[PIN_PEAK];
  assign zero_s = pin_s[PIN_ZERO];

  // Registers
  logic [7:0] command, level_register_set0, level_register_set1;
  logic [4:0] limit_config_register;
  logic [0:0] good_indicator_register;
  logic short_circuit_event, warn_evt, prewarn_evt, hot_evt;
  logic warn_d, prewarn_d, hot_d, en_d;
  run_state_t run_q, next_run;
  sw_phase_t sw_q, next_sw;
  logic pfm_q, next_pfm;
  logic [3:0] peak_cnt;
  logic [2:0] on_cnt;
  logic [10:0] boot_cnt;
  off_timer_if tmr_if ();

  // Set selection: set 0 only when gated and select pin low
  logic use_set0, on_eff, forced_eff, auto_restart_bit, output_discharge_enable;
  assign use_set0 = command[CMD_GATE_BIT] && !sel_s;
  assign on_eff = use_set0 ? command[CMD_ON0_BIT] : command[CMD_ON1_BIT];
  assign forced_eff = use_set0 ? command[CMD_PWM0_BIT] : command[CMD_PWM1_BIT];
  assign auto_restart_bit = limit_config_register[LIM_AUTO_RESTART_BIT_BIT];
  assign output_discharge_enable = good_indicator_register[GOOD_DIS_BIT];

  function automatic logic [31:0] reg_read(input logic [4:0] a);
    logic [31:0] d;
    d = '0;
    if (a == OFS_COMMAND)
      d[7:0] = command;
    else if (a == OFS_LEVEL0)
      d[7:0] = level_register_set0;
    else if (a == OFS_LEVEL1)
      d[7:0] = level_register_set1;
    else if (a == OFS_LIMIT)
      d[4:0] = limit_config_register;
    else if (a == OFS_GOOD)
      d[0] = good_indicator_register[0];
    else if (a == OFS_STATUS)
    begin
      d[STA_SHORT_BIT] = short_circuit_event;
      d[STA_WARN_BIT] = warn_evt;
      d[STA_PREW_BIT] = prewarn_evt;
      d[STA_HOT_BIT] = hot_evt;
      d[STA_PFM_BIT] = pfm_q;
      d[STA_ON_BIT] = O_CONV_ON;
      d[STA_LOCK_BIT] = (run_q == ST_LOCKED);
    end
    return d;
  endfunction

  // Avalon slave: one wait cycle, write lands on the edge waitrequest is low
  logic wr_take, sta_clr_any;
  logic [3:0] sta_clr;
  assign wr_take = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];
  assign sta_clr_any = wr_take && (I_AVS_ADDRESS == OFS_STATUS);
  assign sta_clr = sta_clr_any ? I_AVS_WRITEDATA[3:0] : 4'h0;

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h0000_0000;
    end
    else if (I_CE)
    begin
      if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST)
      begin
        O_AVS_WAITREQUEST <= 1'b0;
        O_AVS_READDATA <= I_AVS_READ ? reg_read(I_AVS_ADDRESS) : 32'h0000_0000;
      end
      else
        O_AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Lockout clears the registers; the enable pin never does
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      command <= RST_COMMAND;
      level_register_set0 <= RST_LEVEL;
      level_register_set1 <= RST_LEVEL;
      limit_config_register <= RST_LIMIT;
      good_indicator_register <= RST_GOOD;
    end
    else if (I_CE)
    begin
      if (low_s)
      begin
        command <= RST_COMMAND;
        level_register_set0 <= RST_LEVEL;
        level_register_set1 <= RST_LEVEL;
        limit_config_register <= RST_LIMIT;
        good_indicator_register <= RST_GOOD;
      end
      else if (wr_take)
      begin
        if (I_AVS_ADDRESS == OFS_COMMAND)
          command <= {I_AVS_WRITEDATA[7:2], 2'b00};
        else if (I_AVS_ADDRESS == OFS_LEVEL0)
          level_register_set0 <= I_AVS_WRITEDATA[7:0];
        else if (I_AVS_ADDRESS == OFS_LEVEL1)
          level_register_set1 <= I_AVS_WRITEDATA[7:0];
        else if (I_AVS_ADDRESS == OFS_LIMIT)
          limit_config_register <= I_AVS_WRITEDATA[4:0];
        else if (I_AVS_ADDRESS == OFS_GOOD)
          good_indicator_register <= I_AVS_WRITEDATA[0:0];
      end
    end
  end

  // Switching phase and mode
  logic short_trip;
  assign short_trip = (run_q == ST_RUN) && (sw_q == SW_HIGH) && peak_s
                      && (peak_cnt == 4'(PEAK_LIMIT - 1));

  always_comb
  begin
    next_sw = sw_q;
    next_pfm = forced_eff ? 1'b0 : pfm_q;
    if (next_run != ST_RUN)
      next_sw = SW_IDLE;
    else
    begin
      case (sw_q)
        SW_IDLE:
          if (dem_s)
            next_sw = SW_HIGH;
        SW_HIGH:
          if (peak_s)
            next_sw = SW_LOW;
          else if (pfm_q && on_cnt == 3'(PFM_ON_CYC - 1))
            next_sw = SW_LOW;
          else if (!pfm_q && !dem_s)
            next_sw = SW_LOW;
        SW_LOW:
          if (zero_s)
          begin
            next_sw = SW_IDLE;
            next_pfm = !forced_eff;
          end
          else if (dem_s)
          begin
            next_sw = SW_HIGH;
            next_pfm = 1'b0;
          end
        default:
          next_sw = SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sw_q <= SW_IDLE;
      pfm_q <= 1'b0;
      on_cnt <= 3'h0;
      O_HS_ON <= 1'b0;
      O_LS_ON <= 1'b0;
      O_PULSE_SKIP_MODE <= 1'b0;
    end
    else if (I_CE)
    begin
      if (low_s)
      begin
        sw_q <= SW_IDLE;
        pfm_q <= 1'b0;
        on_cnt <= 3'h0;
        O_HS_ON <= 1'b0;
        O_LS_ON <= 1'b0;
        O_PULSE_SKIP_MODE <= 1'b0;
      end
      else
      begin
        sw_q <= next_sw;
        pfm_q <= next_pfm;
        on_cnt <= (next_sw == SW_HIGH && sw_q == SW_HIGH) ? on_cnt + 3'h1 : 3'h0;
        O_HS_ON <= (next_sw == SW_HIGH);
        // Pulse-skip lets the low side rest at zero current; fixed mode rectifies
        if (next_run != ST_RUN)
          O_LS_ON <= 1'b0;
        else if (next_pfm)
          O_LS_ON <= (next_sw == SW_LOW);
        else
          O_LS_ON <= (next_sw != SW_HIGH);
        O_PULSE_SKIP_MODE <= next_pfm;
      end
    end
  end

  // Consecutive peak counter
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      peak_cnt <= 4'h0;
    else if (I_CE)
    begin
      if (low_s || run_q != ST_RUN)
        peak_cnt <= 4'h0;
      else if (sw_q == SW_HIGH && next_sw != SW_HIGH)
        peak_cnt <= peak_s ? peak_cnt + 4'h1 : 4'h0;
    end
  end

  // Run state: enable, overheat and short circuit shutdown
  always_comb
  begin
    next_run = run_q;
    case (run_q)
      ST_OFF:
        if (en_s && on_eff)
          next_run = ST_RUN;
      ST_RUN:
        if (!en_s || !on_eff)
          next_run = ST_OFF;
        else if (hot_s)
          next_run = ST_HOT_WAIT;
        else if (short_trip)
          next_run = ST_SHORT_WAIT;
      ST_HOT_WAIT:
        if (!hot_s)
          next_run = auto_restart_bit ? ST_OFF : ST_LOCKED;
      ST_SHORT_WAIT:
        if (tmr_if.done)
          next_run = auto_restart_bit ? ST_OFF : ST_LOCKED;
      ST_LOCKED:
        if (!en_s)
          next_run = ST_OFF;
      default:
        next_run = ST_OFF;
    endcase
  end

  assign tmr_if.clr = low_s;
  assign tmr_if.load = TMR_W'(SHORT_OFF_CYCLES);

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      run_q <= ST_OFF;
      tmr_if.start <= 1'b0;
      en_d <= 1'b0;
      O_CONV_ON <= 1'b0;
      O_SEQ_START <= 1'b0;
    end
    else if (I_CE)
    begin
      if (low_s)
      begin
        run_q <= ST_OFF;
        tmr_if.start <= 1'b0;
        en_d <= 1'b0;
        O_CONV_ON <= 1'b0;
        O_SEQ_START <= 1'b0;
      end
      else
      begin
        run_q <= next_run;
        tmr_if.start <= short_trip;
        en_d <= en_s;
        O_CONV_ON <= (next_run == ST_RUN);
        O_SEQ_START <= en_s && !en_d && (run_q != ST_LOCKED);
      end
    end
  end

  off_timer u_off_timer (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .tmr(tmr_if.tmr)
  );

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      {short_circuit_event, warn_evt, prewarn_evt, hot_evt} <= 4'h0;
      {warn_d, prewarn_d, hot_d} <= 3'h0;
      O_SHORT_CIRCUIT_EVENT <= 1'b0;
    end
    else if (I_CE)
    begin
      if (low_s)
      begin
        {short_circuit_event, warn_evt, prewarn_evt, hot_evt} <= 4'h0;
        {warn_d, prewarn_d, hot_d} <= 3'h0;
        O_SHORT_CIRCUIT_EVENT <= 1'b0;
      end
      else
      begin
        warn_d <= pin_s[PIN_WARN];
        prewarn_d <= pin_s[PIN_PREW];
        hot_d <= hot_s;
        short_circuit_event <= short_trip || (short_circuit_event && !sta_clr[0]);
        O_SHORT_CIRCUIT_EVENT <= short_trip || (short_circuit_event && !sta_clr[0]);
        warn_evt <= (pin_s[PIN_WARN] && !warn_d) || (warn_evt && !sta_clr[1]);
        prewarn_evt <= (pin_s[PIN_PREW] && !prewarn_d)
                       || (prewarn_evt && !sta_clr[2]);
        hot_evt <= (hot_s && !hot_d) || (hot_evt && !sta_clr[3]);
      end
    end
  end

  // Boot discharge window, sleep/off modes and analog settings
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      boot_cnt <= 11'h000;
      O_DISCHARGE <= 1'b0;
      O_SLEEP <= 1'b0;
      O_OFF_MODE <= 1'b0;
      O_TARGET_LEVEL <= RST_LEVEL;
      O_PEAK_CODE <= RST_LIMIT[LIM_PEAK_LSB +: 2];
      O_PREWARN_CODE <= RST_LIMIT[LIM_PREW_LSB +: 2];
    end
    else if (I_CE)
    begin
      if (low_s)
        boot_cnt <= 11'h000;
      else if (boot_cnt != 11'(BOOT_DIS_CYC))
        boot_cnt <= boot_cnt + 11'h001;
      // With the good indicator discharge bit set, discharge during the boot window, and after it whenever the converter is not set to run
      O_DISCHARGE <= output_discharge_enable
                     && (boot_cnt != 11'(BOOT_DIS_CYC) || next_run != ST_RUN);
      if (!en_s)
      begin
        O_SLEEP <= command[CMD_SLEEP_BIT] || sel_s || pin_s[PIN_PULLUP];
        O_OFF_MODE <= !(command[CMD_SLEEP_BIT] || sel_s || pin_s[PIN_PULLUP]);
      end
      else
      begin
        O_SLEEP <= !on_eff;
        O_OFF_MODE <= 1'b0;
      end
      O_TARGET_LEVEL <= use_set0 ? level_register_set0 : level_register_set1;
      O_PEAK_CODE <= limit_config_register[LIM_PEAK_LSB +: 2];
      O_PREWARN_CODE <= limit_config_register[LIM_PREW_LSB +: 2];
    end
  end

  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);

  sequence s_last_peak;
    I_CE && !low_s && short_trip;
  endsequence
  sequence s_short_off;
    I_CE && run_q == ST_SHORT_WAIT && tmr_if.done && !low_s;
  endsequence

  a_forced_no_skip: assert property (I_CE && !low_s && forced_eff |=> !O_PULSE_SKIP_MODE)
    else $error("pulse-skip mode while forced");
  a_drive_exclusive: assert property (!(O_HS_ON && O_LS_ON))
    else $error("both switches on");
  a_skip_low_hold: assert property (I_CE && !low_s && run_q == ST_RUN && next_run == ST_RUN
    && pfm_q && sw_q == SW_LOW && !zero_s && !dem_s |=> O_LS_ON)
    else $error("low side released before zero current");
  a_peak_cut: assert property (I_CE && !low_s && sw_q == SW_HIGH && peak_s |=> !O_HS_ON)
    else $error("high side not cut on peak");
  a_short_trip: assert property (s_last_peak |=> run_q == ST_SHORT_WAIT
    && O_SHORT_CIRCUIT_EVENT && !O_CONV_ON)
    else $error("short shutdown not taken");
  a_short_lock: assert property (s_short_off ##0 !auto_restart_bit |=> run_q == ST_LOCKED)
    else $error("no lock after short without restart");
  a_short_auto_restart_bit: assert property (s_short_off ##0 auto_restart_bit ##1 I_CE && en_s && on_eff
    && !low_s && !hot_s |=> O_CONV_ON)
    else $error("no restart after short off period");
  a_lockout_off: assert property (I_CE && low_s |=> !O_CONV_ON && !O_HS_ON && !O_LS_ON)
    else $error("converter active during lockout");
  a_hot_off: assert property (I_CE && !low_s && run_q == ST_RUN && hot_s |=> !O_CONV_ON
    ##0 run_q == ST_HOT_WAIT)
    else $error("overheat did not stop converter");
  a_level_select: assert property (I_CE && !low_s && use_set0 && $stable(level_register_set0)
    |=> O_TARGET_LEVEL == $past(level_register_set0))
    else $error("wrong voltage set used");
  a_off_mode: assert property (I_CE && !en_s && !command[CMD_SLEEP_BIT] && !sel_s
    && !pin_s[PIN_PULLUP] |=> O_OFF_MODE && !O_SLEEP)
    else $error("off mode not entered");

endmodule

// [tb/host_bus_master.sv]
// Host side of the register bus: an Avalon-MM master with one transfer task.
// Assumes one request at a time, all on the shared clock.
`timescale 1ns/1ns
module host_bus_master (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_wait,
  output logic [4:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  initial
  begin
    o_addr = 5'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0000_0000;
    o_be = 4'hF;
  end

  // Request held until waitrequest is seen low; no latency is assumed
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    do @(posedge i_clk); while (i_wait !== 1'b0);
    q = i_rdata;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // Released data lines must not keep the last value
    o_wdata <= ~d;
  endtask
endmodule

// [tb/buck_converter_control_logic_tb.sv]
// Self-checking bench for the converter control logic.
// Assumes the host model drives the bus; comparators are driven here.
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module buck_converter_control_logic_tb;
  import buck_ctl_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, sel = 1'b0, pu = 1'b0;
  logic lo = 1'b0, hot = 1'b0, dem = 1'b0, pk = 1'b0, zc = 1'b0, wa = 1'b0, pwa = 1'b0;
  logic [4:0] adr;
  logic rd, wr, wreq, hs, ls, psm, con, slp, offm, dis, sce, ss;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  logic [7:0] tl;
  logic [1:0] pc, pwc;
  int n_fail = 0, checks = 0, cyc = 0, n_seq = 0;

  always #25 clk = ~clk;

  host_bus_master u_host (.i_clk(clk), .i_rdata(rdat), .i_wait(wreq), .o_addr(adr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wd), .o_be(be));

  // Short off period shortened so the fault path fits the run
  buck_converter_control_logic #(.SHORT_OFF_CYCLES(20)) u_dut (.I_CLK(clk), .I_RSTN(rstn),
    .I_CE(1'b1), .I_EN_PIN(en), .I_SET_SELECT_PIN(sel), .I_PULLUP_DET(pu),
    .I_LOW_SUPPLY_LOCKOUT(lo), .I_OVERHEAT_SHUTDOWN(hot), .I_WARN_HOT(wa),
    .I_PREWARN_HOT(pwa), .I_HS_DEMAND(dem), .I_PEAK_CMP(pk), .I_ZERO_CMP(zc),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
    .O_HS_ON(hs), .O_LS_ON(ls), .O_PULSE_SKIP_MODE(psm), .O_CONV_ON(con),
    .O_SEQ_START(ss), .O_SLEEP(slp), .O_OFF_MODE(offm), .O_DISCHARGE(dis),
    .O_TARGET_LEVEL(tl), .O_PEAK_CODE(pc), .O_PREWARN_CODE(pwc), .O_SHORT_CIRCUIT_EVENT(sce));

  // Start pulses last one cycle, so each is counted exactly once here
  always @(posedge clk)
    if (ss === 1'b1)
      n_seq++;

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, {24'h00_0000, d}, q);
  endtask

  task automatic rd8(input logic [4:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(q, {24'h00_0000, e})
  endtask

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  initial
  begin
    wt(4);
    rstn <= 1'b1;
    wt(3);
    `CHK(dis, 1'b1)
    rd8(OFS_GOOD, 8'h01);
    rd8(OFS_LIMIT, 8'h03);
    rd8(OFS_COMMAND, 8'h2C);
    rd8(5'h18, 8'h00);
    wr8(OFS_GOOD, 8'h00);
    wt(3);
    `CHK(dis, 1'b0)
    wr8(OFS_GOOD, 8'h01);
    wr8(OFS_LEVEL0, 8'h10);
    wr8(OFS_LEVEL1, 8'h20);
    wt(5);
    `CHK(tl, 8'h10)
    sel <= 1'b1;
    wt(5);
    `CHK(tl, 8'h20)
    sel <= 1'b0;
    wr8(OFS_COMMAND, 8'h0C);
    wt(5);
    `CHK(tl, 8'h20)
    for (int i = 0; i < 4; i++)
    begin
      wr8(OFS_LIMIT, i[7:0]);
      wt(2);
      `CHK(pc, i[1:0])
    end
    `CHK(offm, 1'b1)
    pu <= 1'b1;
    wt(5);
    `CHK(slp, 1'b1)
    pu <= 1'b0;
    en <= 1'b1;
    wt(5);
    `CHK(con, 1'b1)
    `CHK(n_seq, 1)
    wr8(OFS_COMMAND, 8'h08);
    wt(5);
    `CHK({con, slp}, 2'h1)
    wr8(OFS_COMMAND, 8'h44);
    dem <= 1'b1;
    wt(8);
    `CHK(psm, 1'b0)
    `CHK(ls, ~hs)
    dem <= 1'b0;
    zc <= 1'b1;
    wt(8);
    `CHK(psm, 1'b0)
    wr8(OFS_COMMAND, 8'h04);
    zc <= 1'b0;
    dem <= 1'b1;
    wt(3);
    dem <= 1'b0;
    wt(8);
    zc <= 1'b1;
    wt(4);
    `CHK(psm, 1'b1)
    zc <= 1'b0;
    dem <= 1'b1;
    wt(3);
    dem <= 1'b0;
    wt(6);
    `CHK({hs, ls, psm}, 3'h3)
    dem <= 1'b1;
    wt(20);
    `CHK(psm, 1'b0)
    pk <= 1'b1;
    wt(200);
    `CHK({sce, con}, 2'h2)
    wt(60);
    `CHK(con, 1'b0)
    rd8(OFS_STATUS, 8'h41);
    pk <= 1'b0;
    dem <= 1'b0;
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    wt(5);
    `CHK(con, 1'b1)
    `CHK(n_seq, 2)
    hot <= 1'b1;
    wt(5);
    `CHK(con, 1'b0)
    hot <= 1'b0;
    wt(8);
    `CHK(con, 1'b0)
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    rd8(OFS_LEVEL0, 8'h10);
    wr8(OFS_LIMIT, 8'h1B);
    wt(5);
    `CHK(pwc, 2'h2)
    hot <= 1'b1;
    wt(5);
    hot <= 1'b0;
    wt(8);
    `CHK(con, 1'b1)
    wr8(OFS_STATUS, 8'h0F);
    rd8(OFS_STATUS, 8'h20);
    `CHK(sce, 1'b0)
    wa <= 1'b1;
    pwa <= 1'b1;
    wt(4);
    wa <= 1'b0;
    pwa <= 1'b0;
    rd8(OFS_STATUS, 8'h26);
    dem <= 1'b1;
    pk <= 1'b1;
    wt(40);
    `CHK({sce, con}, 2'h2)
    pk <= 1'b0;
    wt(30);
    `CHK({sce, con}, 2'h3)
    rd8(OFS_LEVEL0, 8'h10);
    lo <= 1'b1;
    wt(5);
    `CHK(con, 1'b0)
    lo <= 1'b0;
    wt(5);
    rd8(OFS_LEVEL0, 8'h48);
    test_done;
  end
endmodule
